// ===== hdl/fpm_key_debounce.sv
`timescale 1ns/1ps
module fpm_key_debounce
  import fpm_pkg::*;
#(
  parameter int unsigned N = NUM_KEYS,
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
  input wire logic sys_clk_i,     // System clock
  input wire logic rstn_i,        // Synchronous reset, active low
  input wire logic [N-1:0] key_i, // Raw keys, high when pressed
  fpm_key_if.src kif              // Press pulses and stable levels
);

  localparam int CW = $clog2(DEB_CYC + 1);
  localparam logic [CW-1:0] CNT_END = CW'(DEB_CYC - 1);

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] stable;
    logic [N-1:0] press;
    logic [N-1:0][CW-1:0] cnt;
  } fpm_deb_t;

  fpm_deb_t deb_ff;
  fpm_deb_t nxt_deb;

  // Two-stage sync, then a level must hold DEB_CYC cycles to be taken
  always_comb begin
    nxt_deb = deb_ff;
    nxt_deb.sync1 = key_i;
    nxt_deb.sync2 = deb_ff.sync1;
    nxt_deb.press = '0;
    for (int k = 0; k < N; k++) begin
      if (deb_ff.sync2[k] == deb_ff.stable[k]) begin
        nxt_deb.cnt[k] = '0;
      end else if (deb_ff.cnt[k] == CNT_END) begin
        nxt_deb.cnt[k] = '0;
        nxt_deb.stable[k] = deb_ff.sync2[k]; // [R11]
        nxt_deb.press[k] = deb_ff.sync2[k];  // One pulse on press edge [R11]
      end else begin
        nxt_deb.cnt[k] = deb_ff.cnt[k] + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      deb_ff <= '0;
    end else begin
      deb_ff <= nxt_deb;
    end
  end

  assign kif.press = deb_ff.press;
  assign kif.level = deb_ff.stable;

endmodule : fpm_key_debounce

// ===== hdl/fpm_menu.sv
// Contract
// R01: Normal screen shows the largest present phase current.
// R02: Up/down at top level steps through setting groups A, B, C.
// R03: Confirm on a shown group enters that group's item list.
// R04: In an item, up/down alter candidate; confirm stores it.
// R05: Back after setting leaves the menu to the normal display.
// R06: Reset key anywhere in the menu returns to normal operation.
// R07: Editing and storing work regardless of motor run state.
// R08: Ten seconds without keys in group/item screens returns to current.
// R09: Up/down in normal display show each phase's recorded fault current.
// R10: Back and confirm together open the stored fault record view.
// R11: Keys synchronised, debounced, one event per physical press.
// R12: Uncommitted edit discarded on back, reset or timeout.
`timescale 1ns/1ps
module fpm_menu
  import fpm_pkg::*;
#(
  parameter int unsigned TO_CYC = IDLE_TIMEOUT_CYC,
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
  input wire logic sys_clk_i,                     // 40 MHz system clock
  input wire logic rstn_i,                        // Synchronous reset, active low
  input wire logic [NUM_KEYS-1:0] key_i,          // Raw push buttons, high pressed
  input wire logic [2:0][CUR_W-1:0] phase_cur_i,  // Present phase currents
  input wire logic [2:0][CUR_W-1:0] fault_cur_i,  // Recorded fault currents
  input wire logic [CUR_W-1:0] fault_rec_i,       // Stored fault record word
  output logic [3:0] menu_state_o,                // One-hot menu state
  output logic [2:0] screen_o,                    // Top-level screen index
  output logic [1:0] group_o,                     // Chosen group, 0 = A
  output logic [3:0] item_o,                      // Chosen item index
  output logic [CUR_W-1:0] disp_val_o,            // Value on the display
  output logic store_o,                           // One-cycle store strobe
  output logic [1:0] store_group_o,               // Group of stored value
  output logic [3:0] store_item_o,                // Item of stored value
  output logic [VAL_W-1:0] store_val_o            // Stored value
);

  localparam int TW = $clog2(TO_CYC + 1);
  localparam logic [TW-1:0] IDLE_END = TW'(TO_CYC - 1);
  localparam logic [3:0] ITEM_LAST = 4'(NUM_ITEMS - 1);

  typedef struct packed {
    fpm_state_t st;
    logic [2:0] scr;
    logic [1:0] grp;
    logic [3:0] item;
    logic [VAL_W-1:0] cand;
    logic [TW-1:0] idle;
    logic [CUR_W-1:0] disp;
    logic wr;
    logic [1:0] wr_grp;
    logic [3:0] wr_item;
    logic [VAL_W-1:0] wr_val;
    logic [NUM_GROUPS-1:0][NUM_ITEMS-1:0][VAL_W-1:0] mem;
  } fpm_menu_t;

  fpm_menu_t m_ff;
  fpm_menu_t nxt_m;

  fpm_key_if #(.N(NUM_KEYS)) kif ();

  // Debounced key events
  fpm_key_debounce #(
    .N(NUM_KEYS),
    .DEB_CYC(DEB_CYC)
  ) u_deb (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .key_i(key_i),
    .kif(kif)
  );

  // Largest of three currents
  function automatic logic [CUR_W-1:0] max3(input logic [2:0][CUR_W-1:0] c);
    logic [CUR_W-1:0] m;
    m = c[0];
    if (c[1] > m) begin
      m = c[1];
    end
    if (c[2] > m) begin
      m = c[2];
    end
    return m;
  endfunction : max3

  // Step an index with wrap between limits
  function automatic logic [3:0] step(input logic [3:0] v, input logic up,
                                     input logic [3:0] lo, input logic [3:0] hi);
    if (up) begin
      return (v == hi) ? lo : v + 4'h1;
    end
    return (v == lo) ? hi : v - 4'h1;
  endfunction : step

  logic k_up;
  logic k_dn;
  logic k_cf;
  logic k_bk;
  logic k_rs;
  logic any_key;
  logic combo;
  logic in_menu;
  logic [3:0] scr_nx;

  // Key event decode
  always_comb begin
    k_up = kif.press[KEY_UP];
    k_dn = kif.press[KEY_DOWN];
    k_cf = kif.press[KEY_CONFIRM];
    k_bk = kif.press[KEY_BACK];
    k_rs = kif.press[KEY_RESET];
    any_key = |kif.press;
    combo = (k_cf & kif.level[KEY_BACK]) | (k_bk & kif.level[KEY_CONFIRM]); // [R10]
    in_menu = (m_ff.st == ST_ITEM) || (m_ff.st == ST_EDIT) ||
              ((m_ff.st == ST_TOP) && (m_ff.scr >= SCR_GROUP_A));
    scr_nx = step({1'b0, m_ff.scr}, k_up, {1'b0, SCR_CURRENT}, {1'b0, SCR_GROUP_C});
  end

  // Menu sequencing, storage and display
  always_comb begin
    nxt_m = m_ff;
    nxt_m.wr = 1'b0;
    // Idle timer runs only on group and item screens
    if (!in_menu || any_key) begin
      nxt_m.idle = '0;
    end else begin
      nxt_m.idle = m_ff.idle + 1'b1;
    end
    if (k_rs) begin
      nxt_m.st = ST_TOP; // Abandon menu, edit dropped [R06] [R12]
      nxt_m.scr = SCR_CURRENT;
    end else if (in_menu && (m_ff.idle == IDLE_END)) begin
      nxt_m.st = ST_TOP; // Timeout back to current, edit dropped [R08] [R12]
      nxt_m.scr = SCR_CURRENT;
    end else begin
      unique case (m_ff.st)
        ST_TOP: begin
          if (combo) begin
            nxt_m.st = ST_RECORD; // [R10]
          end else if (k_up || k_dn) begin
            nxt_m.scr = scr_nx[2:0]; // Fault phases and groups A-C [R02] [R09]
          end else if (k_cf && (m_ff.scr >= SCR_GROUP_A)) begin
            nxt_m.st = ST_ITEM; // Enter group item list [R03]
            nxt_m.grp = 2'(m_ff.scr - SCR_GROUP_A);
            nxt_m.item = 4'h0;
          end else if (k_bk) begin
            nxt_m.scr = SCR_CURRENT;
          end
        end
        ST_ITEM: begin
          if (k_up || k_dn) begin
            nxt_m.item = step(m_ff.item, k_up, 4'h0, ITEM_LAST);
          end else if (k_cf) begin
            nxt_m.st = ST_EDIT;
            nxt_m.cand = m_ff.mem[m_ff.grp][m_ff.item];
          end else if (k_bk) begin
            nxt_m.st = ST_TOP; // Leave to normal display [R05]
            nxt_m.scr = SCR_CURRENT;
          end
        end
        ST_EDIT: begin
          if (k_up) begin
            nxt_m.cand = (m_ff.cand == VAL_MAX) ? VAL_MAX : m_ff.cand + 1'b1; // [R04]
          end else if (k_dn) begin
            nxt_m.cand = (m_ff.cand == VAL_RESET) ? VAL_RESET : m_ff.cand - 1'b1; // [R04]
          end else if (k_cf) begin
            // Commit does not look at motor run state [R04] [R07]
            nxt_m.mem[m_ff.grp][m_ff.item] = m_ff.cand;
            nxt_m.wr = 1'b1;
            nxt_m.wr_grp = m_ff.grp;
            nxt_m.wr_item = m_ff.item;
            nxt_m.wr_val = m_ff.cand;
            nxt_m.st = ST_ITEM;
          end else if (k_bk) begin
            nxt_m.st = ST_TOP; // Leave without storing [R05] [R12]
            nxt_m.scr = SCR_CURRENT;
          end
        end
        ST_RECORD: begin
          if (k_bk && !combo) begin
            nxt_m.st = ST_TOP;
            nxt_m.scr = SCR_CURRENT;
          end
        end
      endcase
    end
    // Display word follows the current screen
    unique case (m_ff.st)
      ST_TOP: begin
        if (m_ff.scr == SCR_CURRENT) begin
          nxt_m.disp = max3(phase_cur_i); // [R01]
        end else if (m_ff.scr <= SCR_FAULT_L3) begin
          nxt_m.disp = fault_cur_i[2'(m_ff.scr - SCR_FAULT_L1)]; // [R09]
        end else begin
          nxt_m.disp = CUR_W'(m_ff.scr - SCR_GROUP_A); // Group shown [R02]
        end
      end
      ST_ITEM: nxt_m.disp = CUR_W'(m_ff.mem[m_ff.grp][m_ff.item]);
      ST_EDIT: nxt_m.disp = CUR_W'(m_ff.cand);
      ST_RECORD: nxt_m.disp = fault_rec_i; // [R10]
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      m_ff <= '0;
      m_ff.st <= ST_TOP;
      m_ff.scr <= SCR_CURRENT;
      m_ff.mem <= {(NUM_GROUPS * NUM_ITEMS){VAL_RESET}};
    end else begin
      m_ff <= nxt_m;
    end
  end

  // Outputs from flops
  assign menu_state_o = m_ff.st;
  assign screen_o = m_ff.scr;
  assign group_o = m_ff.grp;
  assign item_o = m_ff.item;
  assign disp_val_o = m_ff.disp;
  assign store_o = m_ff.wr;
  assign store_group_o = m_ff.wr_grp;
  assign store_item_o = m_ff.wr_item;
  assign store_val_o = m_ff.wr_val;

endmodule : fpm_menu

// ===== shared/fpm_key_if.sv
`timescale 1ns/1ps
interface fpm_key_if #(
  parameter int unsigned N = 5
);
  logic [N-1:0] press;
  logic [N-1:0] level;
  modport src (output press, output level);
  modport dst (input press, input level);
endinterface : fpm_key_if

// ===== shared/fpm_pkg.sv
package fpm_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned IDLE_TIMEOUT_S = 10;
  localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);

  // Key positions on the key bus
  localparam int unsigned NUM_KEYS = 5;
  localparam int unsigned KEY_UP = 0;
  localparam int unsigned KEY_DOWN = 1;
  localparam int unsigned KEY_CONFIRM = 2;
  localparam int unsigned KEY_BACK = 3;
  localparam int unsigned KEY_RESET = 4;

  // Menu geometry
  localparam int unsigned NUM_GROUPS = 3;
  localparam int unsigned NUM_ITEMS = 10;
  localparam int unsigned VAL_W = 8;
  localparam int unsigned CUR_W = 16;
  localparam logic [VAL_W-1:0] VAL_RESET = 8'h00;
  localparam logic [VAL_W-1:0] VAL_MAX = 8'hFF;

  // Top-level screens: current, three fault phases, three groups
  localparam logic [2:0] SCR_CURRENT = 3'h0;
  localparam logic [2:0] SCR_FAULT_L1 = 3'h1;
  localparam logic [2:0] SCR_FAULT_L3 = 3'h3;
  localparam logic [2:0] SCR_GROUP_A = 3'h4;
  localparam logic [2:0] SCR_GROUP_C = 3'h6;

  // Menu states, one-hot
  typedef enum logic [3:0] {
    ST_TOP    = 4'h1,
    ST_ITEM   = 4'h2,
    ST_EDIT   = 4'h4,
    ST_RECORD = 4'h8
  } fpm_state_t;

endpackage : fpm_pkg

// ===== verification/fpm_menu_sva.sv
`timescale 1ns/1ps
module fpm_menu_sva
  import fpm_pkg::*;
#(
  parameter int unsigned TO_CYC = 200,
  parameter int unsigned DEB_CYC = 4
) (
  input wire logic sys_clk_i, // Clock
  input wire logic rstn_i, // Reset
  input wire logic [NUM_KEYS-1:0] key_i, // Keys
  input wire logic [2:0][CUR_W-1:0] phase_cur_i, // Currents
  input wire logic [2:0][CUR_W-1:0] fault_cur_i, // Faults
  input wire logic [CUR_W-1:0] fault_rec_i, // Record
  input wire logic [3:0] menu_state_o, // State
  input wire logic [2:0] screen_o, // Screen
  input wire logic [1:0] group_o, // Group
  input wire logic [3:0] item_o, // Item
  input wire logic [CUR_W-1:0] disp_val_o, // Display
  input wire logic store_o, // Strobe
  input wire logic [1:0] store_group_o, // Group
  input wire logic [3:0] store_item_o, // Item
  input wire logic [VAL_W-1:0] store_val_o // Value
);
  logic [CUR_W-1:0] m01;
  logic [CUR_W-1:0] cur_max;
  // Largest present phase current
  assign m01 = (phase_cur_i[1] > phase_cur_i[0]) ? phase_cur_i[1] : phase_cur_i[0];
  assign cur_max = (phase_cur_i[2] > m01) ? phase_cur_i[2] : m01;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Top screen held one cycle back
  sequence s_top_was(logic [2:0] s);
    $past(rstn_i) && $past(menu_state_o) == 4'h1 && $past(screen_o) == s;
  endsequence
  // Edit left for item list
  sequence s_commit;
    $past(menu_state_o) == 4'h4 && menu_state_o == 4'h2;
  endsequence
  chk_current_shown: assert property (s_top_was(3'h0) |-> disp_val_o == $past(cur_max))
    else $error("current display wrong");
  chk_fault_shown: assert property (s_top_was(3'h1) |-> disp_val_o == $past(fault_cur_i[0]))
    else $error("fault display wrong");
  chk_group_shown: assert property (s_top_was(3'h6) |-> disp_val_o == 16'h0002)
    else $error("group display wrong");
  chk_record_shown: assert property ($past(rstn_i) && $past(menu_state_o) == 4'h8
    |-> disp_val_o == $past(fault_rec_i)) else $error("record display wrong");
  chk_store_once: assert property (store_o |=> !store_o)
    else $error("store strobe too long");
  chk_store_edit: assert property (store_o |-> s_commit)
    else $error("store outside edit");
  chk_stored_hold: assert property (!store_o |-> $stable({store_group_o, store_item_o, store_val_o}))
    else $error("stored value moved");
  chk_exit_current: assert property ($past(rstn_i) && $past(menu_state_o) inside {4'h2, 4'h4}
    && menu_state_o == 4'h1 |-> screen_o == 3'h0) else $error("menu exit not to current");
  chk_state_onehot: assert property ($onehot(menu_state_o))
    else $error("state not one-hot");
  chk_index_range: assert property (screen_o <= 3'h6 && item_o <= 4'h9 && group_o <= 2'h2)
    else $error("index out of range");
endmodule : fpm_menu_sva
bind fpm_menu fpm_menu_sva #(.TO_CYC(TO_CYC), .DEB_CYC(DEB_CYC)) i_fpm_menu_sva (.sys_clk_i,
  .rstn_i, .key_i, .phase_cur_i, .fault_cur_i, .fault_rec_i, .menu_state_o, .screen_o,
  .group_o, .item_o, .disp_val_o, .store_o, .store_group_o, .store_item_o, .store_val_o);

// ===== verification/fpm_menu_tb.sv
`timescale 1ns/1ps
module fpm_menu_tb;
  import fpm_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [NUM_KEYS-1:0] key;
  logic [3:0] st;
  logic [2:0] scr;
  logic [1:0] grp;
  logic [3:0] itm;
  logic [CUR_W-1:0] disp;
  logic stb;
  logic [1:0] sg;
  logic [3:0] si;
  logic [VAL_W-1:0] sv;
  int stores = 0;
  int bad_count = 0;
  int cmp_count = 0;
  // Clock at 40 MHz
  always #12.5 sys_clk_i = ~sys_clk_i;
  // Count commit strobes
  always @(negedge sys_clk_i) if (stb === 1'b1) stores++;
  fpm_operator i_fpm_operator (.sys_clk_i(sys_clk_i), .key_o(key));
  fpm_menu #(.TO_CYC(200), .DEB_CYC(4)) i_fpm_menu (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .key_i(key), .phase_cur_i({16'h0210, 16'h0345, 16'h0120}),
    .fault_cur_i({16'h0033, 16'h0022, 16'h0011}), .fault_rec_i(16'hBEEF),
    .menu_state_o(st), .screen_o(scr), .group_o(grp), .item_o(itm), .disp_val_o(disp),
    .store_o(stb), .store_group_o(sg), .store_item_o(si), .store_val_o(sv));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // One press held well past the debounce span
  task automatic tp(input logic [NUM_KEYS-1:0] m);
    i_fpm_operator.tap(m, 10);
  endtask : tp
  task automatic t_nav;
    chk("disp", disp, 32'h0345);
    tp(5'h01);
    chk("screen", scr, 3'h1);
    chk("disp", disp, 32'h0011);
    i_fpm_operator.tap(5'h01, 2);
    chk("screen", scr, 3'h1);
    tp(5'h02);
    tp(5'h02);
    chk("screen", scr, 3'h6);
    chk("disp", disp, 32'h0002);
    tp(5'h02);
    tp(5'h02);
    chk("screen", scr, 3'h4);
    $display("test navigation done");
  endtask : t_nav
  task automatic t_store;
    tp(5'h04);
    chk("state", st, 4'h2);
    chk("group", grp, 2'h0);
    tp(5'h01);
    chk("item", itm, 4'h1);
    tp(5'h04);
    chk("state", st, 4'h4);
    tp(5'h01);
    tp(5'h01);
    tp(5'h02);
    chk("disp", disp, 32'h0001);
    tp(5'h04);
    chk("stores", stores, 1);
    chk("triple", {sg, si, sv}, {2'h0, 4'h1, 8'h01});
    chk("state", st, 4'h2);
    $display("test store done");
  endtask : t_store
  task automatic t_leave;
    tp(5'h04);
    tp(5'h01);
    tp(5'h08);
    chk("state", st, 4'h1);
    chk("screen", scr, 3'h0);
    chk("stores", stores, 1);
    chk("value", sv, 8'h01);
    // Back to group A item 1, dropped candidate must not show
    repeat (3) tp(5'h02);
    tp(5'h04);
    tp(5'h01);
    chk("item", itm, 4'h1);
    chk("disp", disp, 32'h0001);
    tp(5'h08);
    chk("screen", scr, 3'h0);
    tp(5'h02);
    tp(5'h04);
    tp(5'h04);
    tp(5'h10);
    chk("state", st, 4'h1);
    chk("stores", stores, 1);
    tp(5'h02);
    repeat (150) @(negedge sys_clk_i);
    chk("screen", scr, 3'h6);
    repeat (100) @(negedge sys_clk_i);
    chk("screen", scr, 3'h0);
    tp(5'h0C);
    chk("state", st, 4'h8);
    chk("disp", disp, 32'hBEEF);
    tp(5'h08);
    chk("state", st, 4'h1);
    $display("test leave done");
  endtask : t_leave
  task automatic complete_run;
    $display("compared %0d, mismatched %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    repeat (4) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    t_nav();
    t_store();
    t_leave();
    complete_run();
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    bad_count++;
    $display("unexpected watchdog expiry");
    complete_run();
  end
endmodule : fpm_menu_tb

// ===== verification/fpm_operator.sv
`timescale 1ns/1ps
module fpm_operator
  import fpm_pkg::*;
(
  input wire logic sys_clk_i, // Clock
  output logic [NUM_KEYS-1:0] key_o // Keys, high pressed
);
  // All buttons released at start
  initial begin
    key_o = '0;
  end
  // Press, hold, release, then let the menu settle
  task automatic tap(input logic [NUM_KEYS-1:0] m, input int hold);
    @(negedge sys_clk_i);
    key_o = m;
    repeat (hold) @(negedge sys_clk_i);
    key_o = '0;
    repeat (12) @(negedge sys_clk_i);
  endtask : tap
endmodule : fpm_operator
